// *** scr_chan_ctl.sv ***
module scr_chan_ctl import scr_pkg::*; (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// trigger writes, one-cycle strobes
	input wire logic i_start_wr,
	input wire logic i_stop_wr,
	// status and engine strobes
	output logic o_enable,
	output logic o_start_pulse,
	output logic o_stop_pulse
);

	logic en_q, en_d;
	logic ss_q, ss_d;
	logic st_q, st_d;
	logic sp_q, sp_d;
	logic tp_q, tp_d;

	always_comb begin
		en_d = en_q;
		if (st_q) begin
			en_d = 1'b0;
		end else if (ss_q) begin
			en_d = 1'b1;
		end
		// trigger bits drop once status has reached its target
		st_d = i_stop_wr | (st_q & en_q);
		// a pending stop also cancels a pending start
		ss_d = i_start_wr | (ss_q & ~en_q & ~st_q);
		// restart during a transfer tells the engine to drop into wait
		sp_d = i_start_wr;
		tp_d = i_stop_wr;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			en_q <= SCR_RST_STATUS_BIT;
			ss_q <= 1'b0;
			st_q <= 1'b0;
			sp_q <= 1'b0;
			tp_q <= 1'b0;
		end else begin
			en_q <= en_d;
			ss_q <= ss_d;
			st_q <= st_d;
			sp_q <= sp_d;
			tp_q <= tp_d;
		end
	end

	assign o_enable = en_q;
	assign o_start_pulse = sp_q;
	assign o_stop_pulse = tp_q;

endmodule

// *** scr_pkg.sv ***
// Notes on behaviour
// - reading the start trigger register always returns zero.
// - stop trigger clears the enable status bit; the trigger self-clears once status is zero.
// - stopping keeps control registers, shift register, pins and error flags unchanged.
// - stop trigger reads zero, resets to zero, only bits 0 and 1 matter.
// - start trigger sets the channel's read-only enable status bit.
// - enable status reads one while operating, zero while stopped; resets to zero.
// - while enabled, clock buffer ignores writes and follows the transfer's clock.
// - while stopped, clock buffer is software writable and drives the clock pin.
// - with output enable set, data buffer ignores writes and follows the transfer; the code follows it only while channel 0 is enabled, else holds.
// - with output enable clear, data buffer takes writes and drives the data pin.
// - data buffer resets to 03h; bit 0 is channel 0, bit 1 reads one.
// - clock buffer resets to 03h; bit 0 is channel 0, bit 1 reads one.
// - output enable resets to zero; bit 0 enables channel 0 transfer output.
// - start trigger during a transfer stops it into wait, keeping registers and pins.
package scr_pkg;

	localparam int SCR_NUM_CH = 2;
	localparam int SCR_AW = 20;
	localparam int SCR_DW = 8;

	// register indices; the byte address equals the index
	localparam logic [SCR_AW-1:0] SCR_IDX_STATUS = 20'hf0120;
	localparam logic [SCR_AW-1:0] SCR_IDX_START = 20'hf0122;
	localparam logic [SCR_AW-1:0] SCR_IDX_STOP = 20'hf0124;
	localparam logic [SCR_AW-1:0] SCR_IDX_DOUT = 20'hf0128;
	localparam logic [SCR_AW-1:0] SCR_IDX_CKOUT = 20'hf0129;
	localparam logic [SCR_AW-1:0] SCR_IDX_OE = 20'hf012a;

	localparam logic [SCR_DW-1:0] SCR_READ_ZERO = 8'h00;
	localparam logic [SCR_DW-1:0] SCR_FIXED_ONE = 8'h02;
	localparam logic [SCR_DW-1:0] SCR_RST_DOUT = 8'h03;
	localparam logic [SCR_DW-1:0] SCR_RST_CKOUT = 8'h03;
	localparam logic [SCR_DW-1:0] SCR_RST_OE = 8'h00;
	localparam logic [SCR_DW-1:0] SCR_RST_RDATA = 8'h00;
	localparam logic SCR_RST_STATUS_BIT = 1'b0;
	localparam int SCR_BIT_CH0 = 0;

	typedef enum {
		SCR_BUS_IDLE,
		SCR_BUS_ACK
	} scr_bus_st_t;

	typedef struct packed {
		logic [SCR_AW-1:0] addr;
		logic rd;
		logic wr;
		logic [SCR_DW-1:0] wdata;
	} scr_req_t;

	// values produced by the channel 0 transfer engine
	typedef struct packed {
		logic so;
		logic ck;
	} scr_eng_t;

endpackage

// *** scr_run_ctrl.sv ***
// Design decision made here: the Avalon-MM slave port.
module scr_run_ctrl import scr_pkg::*; #(
	parameter int NUM_CH = SCR_NUM_CH
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,

	// avalon-mm slave
	input wire logic [SCR_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [SCR_DW-1:0] i_avs_writedata,
	output logic [SCR_DW-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,

	// channel engines
	input wire scr_eng_t i_eng,
	output logic [NUM_CH-1:0] o_chan_enable,
	output logic [NUM_CH-1:0] o_start_pulse,
	output logic [NUM_CH-1:0] o_stop_pulse,

	// pins of channel 0
	output logic o_sdo,
	output logic o_sck
);

	scr_req_t req;

	scr_bus_st_t bus_q;
	scr_bus_st_t bus_d;

	logic wait_q;
	logic wait_d;

	logic [SCR_DW-1:0] rdata_q;
	logic [SCR_DW-1:0] rdata_d;
	logic [SCR_DW-1:0] rdata_mux;

	logic accept;
	logic wr_acc;

	logic hit_status;
	logic hit_start;
	logic hit_stop;
	logic hit_dout;
	logic hit_ckout;
	logic hit_oe;

	logic [NUM_CH-1:0] start_wr;
	logic [NUM_CH-1:0] stop_wr;
	logic [NUM_CH-1:0] enable;

	logic dout_q;
	logic dout_d;
	logic ckout_q;
	logic ckout_d;
	logic oe_q;
	logic oe_d;

	// request bundle

	always_comb begin
		req.addr = i_avs_address;
		req.rd = i_avs_read;
		req.wr = i_avs_write;
		req.wdata = i_avs_writedata;
	end

	// address decode

	always_comb begin
		hit_status = (req.addr == SCR_IDX_STATUS);
		hit_start = (req.addr == SCR_IDX_START);
		hit_stop = (req.addr == SCR_IDX_STOP);
		hit_dout = (req.addr == SCR_IDX_DOUT);
		hit_ckout = (req.addr == SCR_IDX_CKOUT);
		hit_oe = (req.addr == SCR_IDX_OE);
	end

	// bus handshake: one wait cycle, then a single cycle with waitrequest low.
	// the write lands on the edge that ends that cycle, the same edge at which
	// the master sees waitrequest low, so no request is ever taken twice.

	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		unique case (bus_q)
			SCR_BUS_IDLE: begin
				if (req.rd | req.wr) begin
					bus_d = SCR_BUS_ACK;
					wait_d = 1'b0;
				end
			end
			SCR_BUS_ACK: begin
				bus_d = SCR_BUS_IDLE;
			end
		endcase
	end

	always_comb begin
		accept = (bus_q == SCR_BUS_ACK);
		wr_acc = accept & req.wr;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			bus_q <= SCR_BUS_IDLE;
			wait_q <= 1'b1;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
		end
	end

	// read data
	// trigger registers read as zero; unmapped addresses read as zero too.
	// read data are sampled a cycle before the master takes them, so a
	// status change in that cycle shows on the next read.

	always_comb begin
		rdata_mux = SCR_READ_ZERO;
		if (hit_status) begin
			rdata_mux = SCR_DW'(enable);
		end else if (hit_start) begin
			rdata_mux = SCR_READ_ZERO;
		end else if (hit_stop) begin
			rdata_mux = SCR_READ_ZERO;
		end else if (hit_dout) begin
			rdata_mux = SCR_FIXED_ONE;
			rdata_mux[SCR_BIT_CH0] = dout_q;
		end else if (hit_ckout) begin
			rdata_mux = SCR_FIXED_ONE;
			rdata_mux[SCR_BIT_CH0] = ckout_q;
		end else if (hit_oe) begin
			rdata_mux = SCR_READ_ZERO;
			rdata_mux[SCR_BIT_CH0] = oe_q;
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (bus_q == SCR_BUS_IDLE) begin
			if (req.rd) begin
				rdata_d = rdata_mux;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rdata_q <= SCR_RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// run control per channel; bits above the channel count are ignored

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			start_wr[i] = wr_acc & hit_start & req.wdata[i];
			stop_wr[i] = wr_acc & hit_stop & req.wdata[i];
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
		scr_chan_ctl u_chan (
			.i_sys_clk(i_sys_clk),
			.i_sys_rst(i_sys_rst),
			.i_start_wr(start_wr[g]),
			.i_stop_wr(stop_wr[g]),
			.o_enable(enable[g]),
			.o_start_pulse(o_start_pulse[g]),
			.o_stop_pulse(o_stop_pulse[g])
		);
	end

	// output enable of channel 0

	always_comb begin
		oe_d = oe_q;
		if (wr_acc & hit_oe) begin
			oe_d = req.wdata[SCR_BIT_CH0];
		end
	end

	// data output buffer
	// with output enabled the buffer tracks the transfer only while the
	// channel runs; once stopped it keeps its last level.

	always_comb begin
		dout_d = dout_q;
		if (oe_q) begin
			if (enable[SCR_BIT_CH0]) begin
				dout_d = i_eng.so;
			end else begin
				dout_d = dout_q;
			end
		end else if (wr_acc & hit_dout) begin
			dout_d = req.wdata[SCR_BIT_CH0];
		end
	end

	// clock output buffer

	always_comb begin
		ckout_d = ckout_q;
		if (enable[SCR_BIT_CH0]) begin
			ckout_d = i_eng.ck;
		end else if (wr_acc & hit_ckout) begin
			ckout_d = req.wdata[SCR_BIT_CH0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			oe_q <= SCR_RST_OE[SCR_BIT_CH0];
			dout_q <= SCR_RST_DOUT[SCR_BIT_CH0];
			ckout_q <= SCR_RST_CKOUT[SCR_BIT_CH0];
		end else begin
			oe_q <= oe_d;
			dout_q <= dout_d;
			ckout_q <= ckout_d;
		end
	end

	// outputs, each straight from a flip-flop

	assign o_avs_readdata = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_chan_enable = enable;
	assign o_sdo = dout_q;
	assign o_sck = ckout_q;

endmodule

// *** scr_run_ctrl_asserts.sv ***
module scr_run_chk import scr_pkg::*; #(
	parameter int NUM_CH = SCR_NUM_CH
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// bus
	input wire logic [SCR_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [SCR_DW-1:0] i_avs_writedata,
	input wire logic [SCR_DW-1:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// engines and pins
	input wire scr_eng_t i_eng,
	input wire logic [NUM_CH-1:0] o_chan_enable,
	input wire logic [NUM_CH-1:0] o_start_pulse,
	input wire logic [NUM_CH-1:0] o_stop_pulse,
	input wire logic o_sdo,
	input wire logic o_sck
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	wire logic rd_acc = i_avs_read && !o_avs_waitrequest;
	wire logic wr_acc = i_avs_write && !o_avs_waitrequest;
	start_sets_en_a: assert property (o_start_pulse[0] && !o_stop_pulse[0] |=> o_chan_enable[0])
		else $error("enable not set by start");
	stop_clr_en_a: assert property (o_stop_pulse[0] |=> !o_chan_enable[0])
		else $error("enable not cleared by stop");
	sck_run_a: assert property (o_chan_enable[0] && $past(o_chan_enable[0]) |-> o_sck == $past(i_eng.ck))
		else $error("clock pin not following engine");
	// the enable test at the end tolerates a start landing in the same window
	sck_sw_a: assert property (wr_acc && i_avs_address == SCR_IDX_CKOUT && !o_chan_enable[0]
		|-> ##2 (o_chan_enable[0] || o_sck == $past(i_avs_writedata[0], 2)))
		else $error("clock pin ignores software value");
	start_rd_zero_a: assert property (rd_acc && i_avs_address == SCR_IDX_START |-> o_avs_readdata == SCR_READ_ZERO)
		else $error("start trigger read not zero");
	stop_rd_zero_a: assert property (rd_acc && i_avs_address == SCR_IDX_STOP |-> o_avs_readdata == SCR_READ_ZERO)
		else $error("stop trigger read not zero");
	status_rd_a: assert property (rd_acc && i_avs_address == SCR_IDX_STATUS
		|-> o_avs_readdata == SCR_DW'($past(o_chan_enable)))
		else $error("status read mismatch");
	dout_fixed_a: assert property (rd_acc && i_avs_address == SCR_IDX_DOUT
		|-> o_avs_readdata[SCR_DW-1:1] == SCR_FIXED_ONE[SCR_DW-1:1])
		else $error("data buffer upper bits wrong");
	cover property (o_start_pulse[0]);
	cover property (o_stop_pulse[0]);
	cover property (rd_acc && i_avs_address == SCR_IDX_STATUS);
endmodule

bind scr_run_ctrl scr_run_chk #(.NUM_CH(NUM_CH)) chk_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_eng(i_eng), .o_chan_enable(o_chan_enable),
	.o_start_pulse(o_start_pulse), .o_stop_pulse(o_stop_pulse), .o_sdo(o_sdo), .o_sck(o_sck));

// *** scr_run_ctrl_tb.sv ***
module scr_run_ctrl_tb import scr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [SCR_AW-1:0] i_avs_address = '0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [SCR_DW-1:0] i_avs_writedata = '0;
	scr_eng_t i_eng = '0;
	logic [SCR_DW-1:0] o_avs_readdata, q, d;
	logic o_avs_waitrequest, o_sdo, o_sck;
	logic [1:0] o_chan_enable, o_start_pulse, o_stop_pulse;
	logic eng_run = 1'b0;
	int error_cnt = 0, check_count = 0, cyc = 0;
	logic [SCR_AW-1:0] adr[7] = '{SCR_IDX_STATUS, SCR_IDX_START, SCR_IDX_STOP, SCR_IDX_DOUT,
		SCR_IDX_CKOUT, SCR_IDX_OE, 20'hf0130};
	logic [SCR_DW-1:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};

	always #5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		// the engine values are driven here only, so they idle at zero when stopped
		i_eng <= eng_run ? scr_eng_t'(2'($urandom)) : '0;
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end

	scr_run_ctrl #(.NUM_CH(2)) dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_eng(i_eng), .o_chan_enable(o_chan_enable),
		.o_start_pulse(o_start_pulse), .o_stop_pulse(o_stop_pulse), .o_sdo(o_sdo), .o_sck(o_sck));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp8(input logic [SCR_DW-1:0] exp, input logic [SCR_DW-1:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t pin %b expected %b", $time, got, exp);
		end
	endtask

	// one transfer; the leading edge keeps a release and a new request apart
	task automatic bus(input logic w, input logic [SCR_AW-1:0] a, input logic [SCR_DW-1:0] wd);
		@(posedge i_sys_clk);
		i_avs_address <= a;
		i_avs_writedata <= wd;
		i_avs_write <= w;
		i_avs_read <= !w;
		do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask

	task automatic rd_chk(input logic [SCR_AW-1:0] a, input logic [SCR_DW-1:0] exp);
		bus(1'b0, a, 8'h00);
		cmp8(exp, q);
	endtask

	function automatic logic [SCR_DW-1:0] buf_rd(input logic b);
		return {6'h00, 1'b1, b};
	endfunction

	initial begin
		d = $urandom(32'h343c);
		repeat (8) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		cmp1(1'b1, o_sdo);
		cmp1(1'b1, o_sck);
		for (int i = 0; i < 7; i++)
			rd_chk(adr[i], rv[i]);
		$display("test 1 done");
		bus(1'b1, SCR_IDX_STATUS, 8'hff);
		rd_chk(SCR_IDX_STATUS, 8'h00);
		repeat (8) begin
			d = $urandom;
			bus(1'b1, SCR_IDX_DOUT, d);
			bus(1'b1, SCR_IDX_CKOUT, ~d);
			rd_chk(SCR_IDX_DOUT, buf_rd(d[0]));
			cmp1(d[0], o_sdo);
			rd_chk(SCR_IDX_CKOUT, buf_rd(~d[0]));
			cmp1(~d[0], o_sck);
		end
		$display("test 2 done");
		eng_run <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		bus(1'b1, SCR_IDX_START, 8'h03);
		@(posedge i_sys_clk);
		cmp1(1'b1, o_start_pulse[0]);
		@(posedge i_sys_clk);
		cmp1(1'b1, o_chan_enable[0]);
		rd_chk(SCR_IDX_STATUS, 8'h03);
		rd_chk(SCR_IDX_START, 8'h00);
		bus(1'b1, SCR_IDX_OE, 8'h01);
		repeat (20) @(posedge i_sys_clk);
		eng_run <= 1'b0;
		@(posedge i_sys_clk);
		// pins are looked at right after each write, which the running channel ignores, so they still show the engine's zero
		bus(1'b1, SCR_IDX_CKOUT, 8'h01);
		@(posedge i_sys_clk);
		cmp1(1'b0, o_sck);
		bus(1'b1, SCR_IDX_DOUT, 8'h01);
		@(posedge i_sys_clk);
		cmp1(1'b0, o_sdo);
		rd_chk(SCR_IDX_CKOUT, buf_rd(1'b0));
		bus(1'b1, SCR_IDX_START, 8'h01);
		@(posedge i_sys_clk);
		cmp1(1'b1, o_start_pulse[0]);
		@(posedge i_sys_clk);
		rd_chk(SCR_IDX_STATUS, 8'h03);
		cmp1(1'b0, o_sck);
		$display("test 3 done");
		bus(1'b1, SCR_IDX_STOP, 8'h01);
		@(posedge i_sys_clk);
		cmp1(1'b1, o_stop_pulse[0]);
		@(posedge i_sys_clk);
		rd_chk(SCR_IDX_STATUS, 8'h02);
		rd_chk(SCR_IDX_STOP, 8'h00);
		rd_chk(SCR_IDX_OE, 8'h01);
		cmp1(1'b0, o_sck);
		cmp1(1'b0, o_sdo);
		bus(1'b1, SCR_IDX_DOUT, 8'h01);
		bus(1'b1, SCR_IDX_CKOUT, 8'h01);
		rd_chk(SCR_IDX_CKOUT, buf_rd(1'b1));
		cmp1(1'b1, o_sck);
		cmp1(1'b0, o_sdo);
		bus(1'b1, SCR_IDX_OE, 8'h00);
		bus(1'b1, SCR_IDX_DOUT, 8'h01);
		bus(1'b1, SCR_IDX_STOP, 8'h02);
		@(posedge i_sys_clk);
		cmp1(1'b1, o_stop_pulse[1]);
		@(posedge i_sys_clk);
		rd_chk(SCR_IDX_STATUS, 8'h00);
		cmp1(1'b1, o_sdo);
		$display("test 4 done");
		end_of_test();
	end
endmodule
